/* File: rsbc_reset_ctrl.sv */
// Behaviour
// - Power-on, pin, watchdog, wake-up and brownout are five separate causes, each starting a reset sequence.
// - The boot straps are latched at the end of the sequence and kept until the next power-on, brownout or pin reset.
// - A low reset pin is accepted in normal operation and in power-down.
// - A watchdog malfunction signal starts a reset that leaves the oscillator and PLL out of reset.
// - A pin reset during power-down is a wake-up reset and leaves the RAM valid.
// - During a power-on or brownout reset the RAM is reported not valid.
// - A wake-up reset switches the main regulator back on.
// - Active mode enables both regulators; power-down keeps only the low-power regulator.
// - Three straps select user, bootstrap loader, debug or user JTAG mode, with the start address zero.
`timescale 1ns/1ps
`include "rsbc_regs.svh"
module rsbc_reset_ctrl #(
    parameter int unsigned HOLD_CYC = `RSBC_HOLD_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  reset_pin_n_i,
    input  wire logic                  watchdog_unit_fault_i,
    input  wire logic                  brownout_i,
    input  wire logic                  power_down_req_i,
    input  wire logic                  boot_mode_strap_i,
    input  wire logic                  boot_test_strap_i,
    input  wire logic                  boot_aux_strap_i,
    output logic                       core_rst_o,
    output logic                       periph_rst_o,
    output logic                       osc_pll_rst_o,
    output logic                       port_rst_o,
    output logic                       flash_rst_o,
    output logic                       nmi_disable_o,
    output logic                       ram_valid_o,
    output logic                       main_reg_en_o,
    output logic                       lp_reg_en_o,
    output logic                       power_down_o,
    output rsbc_pkg::rsbc_cause_t      cause_o,
    output rsbc_pkg::rsbc_mode_t       boot_mode_o,
    output logic [15:0]                pc_start_o
);
    import rsbc_pkg::*;

    // ==========================================================
    // Input synchronisation
    rsbc_sync_if sif ();
    logic [5:0] raw_in;
    assign raw_in = {~reset_pin_n_i, watchdog_unit_fault_i, brownout_i,
                     boot_mode_strap_i, boot_test_strap_i, boot_aux_strap_i};
    assign sif.raw = raw_in;
    rsbc_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (sif)
    );

    logic       pin_low;
    logic       wdt_s;
    logic       brown_s;
    logic [2:0] straps_s;
    assign pin_low  = sif.synced[5];
    assign wdt_s    = sif.synced[4];
    assign brown_s  = sif.synced[3];
    assign straps_s = sif.synced[2:0];

    // ==========================================================
    // Sequencer
    typedef enum logic [1:0] {ST_RESET, ST_ACTIVE, ST_SLEEP} rsbc_state_t;

    localparam logic [`RSBC_CNT_W-1:0] PIN_CYC = `RSBC_CNT_W'(`RSBC_PIN_LOW_CYC);
    localparam logic [`RSBC_CNT_W-1:0] HOLD    = `RSBC_CNT_W'(HOLD_CYC);

    rsbc_state_t             st_q, st_d;
    rsbc_cause_t             cause_q, cause_d;
    rsbc_mode_t              mode_q, mode_d;
    logic [`RSBC_CNT_W-1:0]  pin_cnt_q, pin_cnt_d;
    logic [`RSBC_CNT_W-1:0]  hold_q, hold_d;
    logic                    pin_seen_q, pin_seen_d;
    logic                    ram_q, ram_d;
    logic                    nmi_q, nmi_d;
    logic                    osc_q, osc_d;
    logic                    first_q, first_d;
    logic                    pin_rst;
    logic                    any_src;

    // Pin reset is recognised once the low level has lasted the minimum time.
    assign pin_rst = pin_low && (pin_cnt_q >= PIN_CYC);
    assign any_src = pin_rst || wdt_s || brown_s;

    always_comb begin
        st_d       = st_q;
        cause_d    = cause_q;
        mode_d     = mode_q;
        hold_d     = hold_q;
        ram_d      = ram_q;
        nmi_d      = nmi_q;
        osc_d      = osc_q;
        first_d    = first_q;
        pin_seen_d = pin_seen_q;
        pin_cnt_d  = pin_low ? ((pin_cnt_q == PIN_CYC) ? pin_cnt_q : pin_cnt_q + 1'b1) : '0;
        if (any_src) begin
            st_d   = ST_RESET;
            hold_d = HOLD;
            if (brown_s) begin
                cause_d = RSBC_CAUSE_BROWN;
                ram_d   = 1'b0;
                osc_d   = 1'b1;
                nmi_d   = 1'b0;
            // A pin that is still low after the wake-up was recognised keeps the wake-up cause.
            end else if (pin_rst && (st_q == ST_SLEEP || (st_q == ST_RESET && cause_q == RSBC_CAUSE_WAKE))) begin
                cause_d = RSBC_CAUSE_WAKE;
                nmi_d   = 1'b1;
                osc_d   = 1'b1;
            end else if (pin_rst) begin
                cause_d    = first_q ? RSBC_CAUSE_PON : RSBC_CAUSE_HW;
                pin_seen_d = 1'b1;
                osc_d      = 1'b1;
                nmi_d      = 1'b0;
                if (first_q) begin
                    ram_d = 1'b0;
                end
            end else if (st_q != ST_RESET || cause_q == RSBC_CAUSE_WDT) begin
                cause_d = RSBC_CAUSE_WDT;
                nmi_d   = 1'b1;
                osc_d   = 1'b0;
            end
        end else begin
            unique case (st_q)
                ST_RESET: begin
                    // A pin held low through power-up keeps the sequence waiting, so it is classed power-on.
                    if (pin_low) begin
                        st_d = ST_RESET;
                    end else if (hold_q != '0) begin
                        hold_d = hold_q - 1'b1;
                    end else begin
                        st_d    = ST_ACTIVE;
                        first_d = 1'b0;
                        ram_d   = 1'b1;
                        // Straps are only re-read after power-on, brownout or pin reset.
                        if (cause_q == RSBC_CAUSE_PON || cause_q == RSBC_CAUSE_HW ||
                            cause_q == RSBC_CAUSE_BROWN || pin_seen_q) begin
                            mode_d = rsbc_decode_boot(straps_s);
                        end
                        pin_seen_d = 1'b0;
                    end
                end
                ST_ACTIVE: begin
                    if (power_down_req_i) begin
                        st_d = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    st_d = ST_SLEEP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q       <= ST_RESET;
            cause_q    <= RSBC_CAUSE_PON;
            mode_q     <= RSBC_MODE_INVALID;
            hold_q     <= HOLD;
            pin_cnt_q  <= '0;
            pin_seen_q <= 1'b0;
            ram_q      <= 1'b0;
            nmi_q      <= 1'b0;
            osc_q      <= 1'b1;
            first_q    <= 1'b1;
        end else begin
            st_q       <= st_d;
            cause_q    <= cause_d;
            mode_q     <= mode_d;
            hold_q     <= hold_d;
            pin_cnt_q  <= pin_cnt_d;
            pin_seen_q <= pin_seen_d;
            ram_q      <= ram_d;
            nmi_q      <= nmi_d;
            osc_q      <= osc_d;
            first_q    <= first_d;
        end
    end

    // ==========================================================
    // Registered outputs
    logic in_rst_d;
    logic rd_d;
    logic main_d;
    assign in_rst_d = (st_d == ST_RESET);
    assign rd_d     = ram_d && (st_d != ST_RESET || cause_d == RSBC_CAUSE_WAKE ||
                                cause_d == RSBC_CAUSE_WDT || cause_d == RSBC_CAUSE_HW);
    assign main_d   = (st_d != ST_SLEEP);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_rst_o    <= 1'b1;
            periph_rst_o  <= 1'b1;
            osc_pll_rst_o <= 1'b1;
            port_rst_o    <= 1'b1;
            flash_rst_o   <= 1'b1;
            nmi_disable_o <= 1'b0;
            ram_valid_o   <= 1'b0;
            main_reg_en_o <= 1'b1;
            lp_reg_en_o   <= 1'b1;
            power_down_o  <= 1'b0;
            cause_o       <= RSBC_CAUSE_PON;
            boot_mode_o   <= RSBC_MODE_INVALID;
            pc_start_o    <= `RSBC_PC_START;
        end else begin
            core_rst_o    <= in_rst_d;
            periph_rst_o  <= in_rst_d;
            osc_pll_rst_o <= in_rst_d && osc_d;
            port_rst_o    <= in_rst_d;
            flash_rst_o   <= in_rst_d;
            nmi_disable_o <= nmi_d;
            ram_valid_o   <= rd_d;
            main_reg_en_o <= main_d;
            lp_reg_en_o   <= 1'b1;
            power_down_o  <= (st_d == ST_SLEEP);
            cause_o       <= cause_d;
            boot_mode_o   <= mode_d;
            pc_start_o    <= `RSBC_PC_START;
        end
    end
endmodule : rsbc_reset_ctrl

/* File: rsbc_regs.svh */
`ifndef RSBC_REGS_SVH
`define RSBC_REGS_SVH

// Reset pin low time needed for recognition, in ns.
`define RSBC_PIN_LOW_NS       100
`define RSBC_CLK_PERIOD_NS    4
// Least time rounds up to whole cycles.
`define RSBC_PIN_LOW_CYC      ((`RSBC_PIN_LOW_NS + `RSBC_CLK_PERIOD_NS - 1) / `RSBC_CLK_PERIOD_NS)
// Cycles the internal resets stay asserted after the cause is gone.
`define RSBC_HOLD_CYC         16
`define RSBC_CNT_W            8
`define RSBC_PC_START         16'h0000
`define RSBC_BOOT_RST         3'h4
`define RSBC_CAUSE_RST        3'h0

`endif

/* File: rsbc_pkg.sv */
package rsbc_pkg;

    typedef enum logic [2:0] {
        RSBC_CAUSE_PON,
        RSBC_CAUSE_HW,
        RSBC_CAUSE_WDT,
        RSBC_CAUSE_WAKE,
        RSBC_CAUSE_BROWN
    } rsbc_cause_t;

    typedef enum logic [2:0] {
        RSBC_MODE_USER,
        RSBC_MODE_BOOTLOADER,
        RSBC_MODE_DEBUG,
        RSBC_MODE_JTAG_USER,
        RSBC_MODE_INVALID
    } rsbc_mode_t;

    function automatic rsbc_mode_t rsbc_decode_boot(input logic [2:0] pins);
        rsbc_decode_boot = RSBC_MODE_INVALID;
        if (pins[2:1] == 2'b10) begin
            rsbc_decode_boot = RSBC_MODE_USER;
        end else if (pins[2:1] == 2'b00) begin
            rsbc_decode_boot = RSBC_MODE_BOOTLOADER;
        end else if (pins == 3'b010) begin
            rsbc_decode_boot = RSBC_MODE_DEBUG;
        end else if (pins == 3'b110) begin
            rsbc_decode_boot = RSBC_MODE_JTAG_USER;
        end
    endfunction : rsbc_decode_boot

endpackage : rsbc_pkg

/* File: rsbc_sync_if.sv */
`timescale 1ns/1ps
interface rsbc_sync_if;
    logic [5:0] raw;
    logic [5:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface : rsbc_sync_if

/* File: rsbc_sync.sv */
`timescale 1ns/1ps
module rsbc_sync (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    rsbc_sync_if.snk   bus
);
    logic [5:0] meta_q;
    logic [5:0] meta_d;
    logic [5:0] sync_q;
    logic [5:0] sync_d;

    always_comb begin
        meta_d = bus.raw;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign bus.synced = sync_q;
endmodule : rsbc_sync

/* File: rsbc_reset_ctrl_monitor.sv */
`timescale 1ns/1ps
// ============================================================
// Port checker for the reset sequencer.
module rsbc_reset_ctrl_monitor
    import rsbc_pkg::*;
#(
    parameter int unsigned HOLD_CYC = 16
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  reset_pin_n_i,
    input wire logic                  watchdog_unit_fault_i,
    input wire logic                  brownout_i,
    input wire logic                  core_rst_o,
    input wire logic                  osc_pll_rst_o,
    input wire logic                  nmi_disable_o,
    input wire logic                  ram_valid_o,
    input wire logic                  main_reg_en_o,
    input wire logic                  lp_reg_en_o,
    input wire logic                  power_down_o,
    input wire rsbc_pkg::rsbc_cause_t cause_o,
    input wire rsbc_pkg::rsbc_mode_t  boot_mode_o,
    input wire logic [15:0]           pc_start_o
);
    // Counts how long the reset pin has been low, saturating.
    logic [7:0] low_q, low_d;
    always_comb low_d = reset_pin_n_i ? 8'h00 : ((low_q == 8'hFF) ? low_q : low_q + 8'h01);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) low_q <= 8'h00;
        else low_q <= low_d;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pin_gone; $rose(reset_pin_n_i) && core_rst_o; endsequence
    sequence s_quiet; !core_rst_o ##1 !core_rst_o; endsequence
    property p_fixed; lp_reg_en_o && pc_start_o == 16'h0000; endproperty
    a_fixed: assert property (p_fixed) else $error("regulator or start address wrong");
    property p_pd_main; power_down_o ##1 power_down_o |-> !main_reg_en_o; endproperty
    a_pd_main: assert property (p_pd_main) else $error("main regulator on in power-down");
    property p_wake; core_rst_o && cause_o == RSBC_CAUSE_WAKE |-> ram_valid_o ##[0:2] main_reg_en_o; endproperty
    a_wake: assert property (p_wake) else $error("wake-up lost RAM or regulator");
    property p_cold_ram; core_rst_o && cause_o inside {RSBC_CAUSE_PON, RSBC_CAUSE_BROWN} |-> ##[0:1] !ram_valid_o; endproperty
    a_cold_ram: assert property (p_cold_ram) else $error("RAM valid after cold reset");
    property p_nmi; core_rst_o && cause_o inside {RSBC_CAUSE_WAKE, RSBC_CAUSE_WDT} |=> nmi_disable_o; endproperty
    a_nmi: assert property (p_nmi) else $error("NMI not disabled");
    property p_wdt_osc; core_rst_o && cause_o == RSBC_CAUSE_WDT |-> !osc_pll_rst_o; endproperty
    a_wdt_osc: assert property (p_wdt_osc) else $error("clock unit reset by watchdog");
    property p_wdt; $rose(watchdog_unit_fault_i) && !core_rst_o |-> ##[1:5] (core_rst_o && cause_o == RSBC_CAUSE_WDT); endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
    property p_brown; $rose(brownout_i) |-> ##[1:5] (core_rst_o && cause_o == RSBC_CAUSE_BROWN); endproperty
    a_brown: assert property (p_brown) else $error("brownout reset missing");
    property p_pin; low_q == 8'd35 |-> core_rst_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset not seen");
    property p_hold; s_pin_gone |-> core_rst_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("reset released early");
    property p_boot; s_quiet |-> $stable(boot_mode_o); endproperty
    a_boot: assert property (p_boot) else $error("boot mode changed in operation");
endmodule : rsbc_reset_ctrl_monitor

bind rsbc_reset_ctrl rsbc_reset_ctrl_monitor #(.HOLD_CYC(HOLD_CYC)) mon_u (
    .clk_i, .rst_i, .reset_pin_n_i, .watchdog_unit_fault_i, .brownout_i, .core_rst_o, .osc_pll_rst_o,
    .nmi_disable_o, .ram_valid_o, .main_reg_en_o, .lp_reg_en_o, .power_down_o, .cause_o, .boot_mode_o,
    .pc_start_o);

/* File: rsbc_board.sv */
`timescale 1ns/1ps
// ============================================================
// Board reset circuit and boot straps; the pin idles high on its pull-up.
module rsbc_board (
    input  wire logic  clk_i,
    output logic       reset_pin_n_o,
    output logic [2:0] straps_o
);
    initial begin
        reset_pin_n_o = 1'b1;
        straps_o = 3'h4;
    end
    task automatic set_straps(input logic [2:0] v);
        @(negedge clk_i) straps_o = v;
    endtask : set_straps
    task automatic pulse(input int n);
        @(negedge clk_i) reset_pin_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        reset_pin_n_o = 1'b1;
    endtask : pulse
endmodule : rsbc_board

/* File: test_reset_source_boot_control.sv */
`timescale 1ns/1ps
// ============================================================
// Testbench.
module test_reset_source_boot_control;
    import rsbc_pkg::*;
    typedef struct packed { logic [2:0] st; rsbc_mode_t m; } rsbc_row_t;
    logic clk_i, rst_i, wdt, brown, pd_req, pin_n, core, osc, nmi, ram, men, lpen, pd;
    logic per, prt, fl;
    logic [2:0] st;
    logic [15:0] pc;
    rsbc_cause_t cause;
    rsbc_mode_t mode;
    int bad_count = 0;
    int n_compared = 0;
    rsbc_row_t rows [8] = '{'{3'h4, RSBC_MODE_USER}, '{3'h5, RSBC_MODE_USER}, '{3'h0, RSBC_MODE_BOOTLOADER},
        '{3'h1, RSBC_MODE_BOOTLOADER}, '{3'h2, RSBC_MODE_DEBUG}, '{3'h3, RSBC_MODE_INVALID},
        '{3'h7, RSBC_MODE_INVALID}, '{3'h6, RSBC_MODE_JTAG_USER}};
    rsbc_board brd_u (.clk_i, .reset_pin_n_o(pin_n), .straps_o(st));
    rsbc_reset_ctrl dut_u (.clk_i, .rst_i, .reset_pin_n_i(pin_n), .watchdog_unit_fault_i(wdt), .brownout_i(brown),
        .power_down_req_i(pd_req), .boot_mode_strap_i(st[2]), .boot_test_strap_i(st[1]), .boot_aux_strap_i(st[0]),
        .core_rst_o(core), .periph_rst_o(per), .osc_pll_rst_o(osc), .port_rst_o(prt), .flash_rst_o(fl),
        .nmi_disable_o(nmi), .ram_valid_o(ram), .main_reg_en_o(men), .lp_reg_en_o(lpen), .power_down_o(pd),
        .cause_o(cause), .boot_mode_o(mode), .pc_start_o(pc));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Waits, bounded, for a reset sequence to start and then to end.
    task automatic settle();
        int i;
        i = 0;
        while (core !== 1'b1 && i < 10) begin @(negedge clk_i); i++; end
        while (core !== 1'b0 && i < 300) begin @(negedge clk_i); i++; end
        @(negedge clk_i);
    endtask : settle
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
    initial begin
        rst_i = 1'b1; wdt = 1'b0; brown = 1'b0; pd_req = 1'b0;
        // The board holds the pin low through power-up, so the first sequence is a power-on reset.
        fork
            brd_u.pulse(40);
        join_none
        repeat (2) @(negedge clk_i);
        chk("reset cause", RSBC_CAUSE_PON, cause);
        chk("reset mode", RSBC_MODE_INVALID, mode);
        rst_i = 1'b0;
        settle();
        chk("pon cause", RSBC_CAUSE_PON, cause);
        chk("pon mode", RSBC_MODE_USER, mode);
        chk("run domains", 4'h0, {core, per, prt, fl});
        foreach (rows[i]) begin
            brd_u.set_straps(rows[i].st);
            brd_u.pulse(30);
            settle();
            chk("cause", RSBC_CAUSE_HW, cause);
            chk("boot mode", rows[i].m, mode);
            chk("pc", 16'h0000, pc);
        end
        brd_u.set_straps(3'h0);
        brd_u.pulse(10);
        repeat (6) @(negedge clk_i);
        chk("short pulse", 1'b0, core);
        wdt = 1'b1;
        @(negedge clk_i) wdt = 1'b0;
        repeat (5) @(negedge clk_i);
        chk("wdt cause", RSBC_CAUSE_WDT, cause);
        chk("wdt osc", 2'b10, {core, osc});
        chk("wdt domains", 4'hF, {core, per, prt, fl});
        settle();
        chk("wdt nmi", 1'b1, nmi);
        chk("wdt mode", RSBC_MODE_JTAG_USER, mode);
        brown = 1'b1;
        repeat (5) @(negedge clk_i);
        chk("brown cause", RSBC_CAUSE_BROWN, cause);
        chk("brown ram", 1'b0, ram);
        brown = 1'b0;
        settle();
        chk("brown nmi", 1'b0, nmi);
        chk("brown mode", RSBC_MODE_BOOTLOADER, mode);
        pd_req = 1'b1;
        @(negedge clk_i) pd_req = 1'b0;
        repeat (3) @(negedge clk_i);
        chk("pd regs", 3'b101, {pd, men, lpen});
        brd_u.pulse(30);
        settle();
        chk("wake cause", RSBC_CAUSE_WAKE, cause);
        chk("wake state", 4'b1110, {ram, men, nmi, pd});
        stop_test();
    end
endmodule : test_reset_source_boot_control
